// ---- bench/ampcfg_host.sv ----
// Serial host model that frames register accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module ampcfg_host (
	// Clock
	input wire logic clk_i,
	// Device readback pins
	input wire logic sdio_d_i,
	input wire logic sdio_oe_i,
	input wire logic sdo_d_i,
	input wire logic sdo_oe_i,
	// Serial pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdio_o
);
	logic lsb = 1'b0;
	logic four = 1'b0;
	logic smp;
	logic [7:0] wr_b [2];
	logic [7:0] rd_b [2];
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		sdio_o = 1'b1;
	end
	// ****************************************
	// One bit: set at the fall, read at the rise
	// ****************************************
	// A released line flips so a stale level never passes
	task automatic bit_io(input logic b, input logic drv);
		@(negedge clk_i);
		sclk_o = 1'b0;
		sdio_o = drv ? b : ~sdio_o;
		repeat (8) @(negedge clk_i);
		smp = four ? (sdo_oe_i ? sdo_d_i : 1'bx) : (sdio_oe_i ? sdio_d_i : 1'bx);
		sclk_o = 1'b1;
		repeat (7) @(negedge clk_i);
	endtask
	// ****************************************
	// Whole frame: instruction then n bytes
	// ****************************************
	task automatic frame(input logic rd, input logic [14:0] a, input int n);
		logic [15:0] ins;
		ins = {rd, a};
		@(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		for (int i = 0; i < 16; i++) begin
			bit_io(lsb ? ins[i] : ins[15-i], 1'b1);
		end
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 8; i++) begin
				bit_io(lsb ? wr_b[k][i] : wr_b[k][7-i], !rd);
				rd_b[k][lsb ? i : 7-i] = smp;
			end
		end
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		repeat (8) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the amplifier configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ampcfg_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic conv_done_i = 1'b1;
	logic [7:0] conv_result_i = 8'hBD;
	wire logic sclk, cs_n, host_d, sdio_d, sdio_oe, sdo_d, sdo_oe, sr, aux_a, aux_b;
	wire logic sdio_w = sdio_oe ? sdio_d : host_d;
	ampcfg_ctrl_t ctrl;
	ampcfg_iface_t ifc;
	int bad_count = 0;
	int checks_done = 0;
	int sr_n = 0;
	int aa_n = 0;
	int ab_n = 0;
	logic [7:0] v, c, d, e;
	logic [7:0] ofs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h10, 8'h18, 8'h19, 8'h1B, 8'h1C, 8'h1D};
	logic [7:0] rstv [14] = '{8'h00, 8'h00, 8'h00, 8'hA5, 8'h12, 8'h34, 8'h5A, 8'h00, 8'h39, 8'h00, 8'hA0, 8'h00, 8'h01, 8'hBD};
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	ampcfg_regs i_ampcfg_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
		.spi_sdio_i(sdio_w), .spi_sdio_o(sdio_d), .spi_sdio_oe_o(sdio_oe), .spi_sdo_o(sdo_d), .spi_sdo_oe_o(sdo_oe),
		.conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .amp_ctrl_o(ctrl), .iface_o(ifc),
		.soft_reset_o(sr), .aux_reset_a_o(aux_a), .aux_reset_b_o(aux_b));
	ampcfg_host i_host (.clk_i(clk_i), .sdio_d_i(sdio_w), .sdio_oe_i(sdio_oe), .sdo_d_i(sdo_d), .sdo_oe_i(sdo_oe),
		.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(host_d));
	// Pulse counters, so a stretched or doubled pulse shows up; sampled away from the launching edge
	always @(negedge clk_i) begin
		if (sr === 1'b1) sr_n++;
		if (aux_a === 1'b1) aa_n++;
		if (aux_b === 1'b1) ab_n++;
	end
	// ****************************************
	// Expectation, comparison and bus tasks
	// ****************************************
	function automatic logic [7:0] exp_a(input logic [7:0] w);
		return {1'b0, w[1], w[2], w[3], w[3:1], 1'b0};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] dv);
		i_host.wr_b[0] = dv;
		i_host.frame(1'b0, a, 1);
	endtask
	task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
		i_host.frame(1'b1, a, 1);
		chk(i_host.rd_b[0], exp);
	endtask
	task automatic stream(input logic [14:0] a, input logic [7:0] b0, input logic [7:0] b1);
		i_host.wr_b[0] = b0;
		i_host.wr_b[1] = b1;
		i_host.frame(1'b0, a, 2);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk_i);
		bad_count++;
		print_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		v = 8'($urandom(32'h680bd863));
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk(ctrl, {AMPCFG_RST_POWER, AMPCFG_RST_CM_TRIM, AMPCFG_RST_OUT_TRIM, AMPCFG_RST_CONV_START});
		chk(ifc, 5'h00);
		for (int i = 0; i < 14; i++) rdchk({7'h00, ofs[i]}, rstv[i]);
		wr(AMPCFG_OFS_CATEGORY, 8'hFF);
		rdchk(AMPCFG_OFS_CATEGORY, 8'hA5);
		wr(15'h0002, 8'h77);
		rdchk(15'h0002, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom);
			wr(AMPCFG_OFS_SCRATCH, v);
			rdchk(AMPCFG_OFS_SCRATCH, v);
		end
		conv_result_i = 8'($urandom);
		conv_done_i = 1'b0;
		rdchk(AMPCFG_OFS_CONV_RESULT, conv_result_i);
		rdchk(AMPCFG_OFS_CONV_DONE, 8'h00);
		// Converter start keeps only its two low bits
		v = 8'($urandom);
		wr(AMPCFG_OFS_CONV_START, v);
		rdchk(AMPCFG_OFS_CONV_START, {6'h00, v[1:0]});
		chk(ctrl.conv_start, v[1:0]);
		// Streams both ways, then one byte only under single transfer
		c = 8'($urandom);
		d = 8'($urandom);
		e = 8'($urandom);
		wr(AMPCFG_OFS_CFG_A, 8'h04);
		rdchk(AMPCFG_OFS_CFG_A, exp_a(8'h04));
		stream(AMPCFG_OFS_CM_TRIM, d, c);
		chk({ctrl.cm_trim, ctrl.out_trim}, {d, c});
		wr(AMPCFG_OFS_CFG_A, 8'h00);
		stream(AMPCFG_OFS_OUT_TRIM, e, c);
		chk({ctrl.cm_trim, ctrl.out_trim}, {c, e});
		i_host.frame(1'b1, AMPCFG_OFS_OUT_TRIM, 2);
		chk({i_host.rd_b[0], i_host.rd_b[1]}, {e, c});
		wr(AMPCFG_OFS_CFG_B, 8'hC0);
		rdchk(AMPCFG_OFS_CFG_B, 8'hC0);
		chk(ifc, 5'h18);
		wr(AMPCFG_OFS_CFG_A, 8'h04);
		stream(AMPCFG_OFS_CM_TRIM, d, 8'h00);
		chk({ctrl.cm_trim, ctrl.out_trim}, {d, e});
		wr(AMPCFG_OFS_CFG_B, 8'h00);
		for (int i = 1; i < 4; i++) begin
			v = 8'(i * 2);
			c = 8'(aa_n);
			d = 8'(ab_n);
			wr(AMPCFG_OFS_CFG_B, v);
			chk({8'(aa_n) - c, 8'(ab_n) - d}, {7'h00, v[1], 7'h00, v[2]});
			rdchk(AMPCFG_OFS_CFG_B, 8'h00);
		end
		// Four-wire, LSB first, then back
		wr(AMPCFG_OFS_CFG_A, 8'h0E);
		i_host.lsb = 1'b1;
		i_host.four = 1'b1;
		chk(ifc, 5'h07);
		rdchk(AMPCFG_OFS_CFG_A, exp_a(8'h0E));
		v = 8'($urandom);
		wr(AMPCFG_OFS_SCRATCH, v);
		rdchk(AMPCFG_OFS_SCRATCH, v);
		wr(AMPCFG_OFS_CFG_A, 8'h00);
		i_host.lsb = 1'b0;
		i_host.four = 1'b0;
		rdchk(AMPCFG_OFS_CFG_A, 8'h00);
		// Soft reset restores writable registers; move them off reset values first
		wr(AMPCFG_OFS_POWER, 8'h00);
		chk(ctrl.power_down, 8'h00);
		wr(AMPCFG_OFS_SCRATCH, 8'hC3);
		rdchk(AMPCFG_OFS_SCRATCH, 8'hC3);
		c = 8'(sr_n);
		wr(AMPCFG_OFS_CFG_A, 8'h01);
		chk(8'(sr_n) - c, 8'h01);
		rdchk(AMPCFG_OFS_CFG_A, 8'h00);
		rdchk(AMPCFG_OFS_SCRATCH, AMPCFG_RST_SCRATCH);
		rdchk(AMPCFG_OFS_POWER, AMPCFG_RST_POWER);
		chk(ctrl.power_down, AMPCFG_RST_POWER);
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- design/ampcfg_pkg.sv ----
// Shared constants and types of the amplifier configuration register bank
package ampcfg_pkg;

	// ****************************************
	// Serial frame geometry
	// ****************************************
	localparam int AMPCFG_ADDR_W = 15;
	localparam int AMPCFG_INSTR_BITS = 16;
	localparam int AMPCFG_DATA_BITS = 8;
	localparam logic [3:0] AMPCFG_INSTR_LAST = 4'hF;
	localparam logic [3:0] AMPCFG_DATA_LAST = 4'h7;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [14:0] AMPCFG_OFS_CFG_A = 15'h0000;
	localparam logic [14:0] AMPCFG_OFS_CFG_B = 15'h0001;
	localparam logic [14:0] AMPCFG_OFS_CATEGORY = 15'h0003;
	localparam logic [14:0] AMPCFG_OFS_VARIANT_LO = 15'h0004;
	localparam logic [14:0] AMPCFG_OFS_VARIANT_HI = 15'h0005;
	localparam logic [14:0] AMPCFG_OFS_REVISION = 15'h0006;
	localparam logic [14:0] AMPCFG_OFS_SCRATCH = 15'h000A;
	localparam logic [14:0] AMPCFG_OFS_POWER = 15'h0010;
	localparam logic [14:0] AMPCFG_OFS_CM_TRIM = 15'h0018;
	localparam logic [14:0] AMPCFG_OFS_OUT_TRIM = 15'h0019;
	localparam logic [14:0] AMPCFG_OFS_CONV_START = 15'h001B;
	localparam logic [14:0] AMPCFG_OFS_CONV_DONE = 15'h001C;
	localparam logic [14:0] AMPCFG_OFS_CONV_RESULT = 15'h001D;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int AMPCFG_A_RESET_BIT = 0;
	localparam int AMPCFG_A_ORDER_BIT = 1;
	localparam int AMPCFG_A_ASCEND_BIT = 2;
	localparam int AMPCFG_A_PIN_BIT = 3;
	localparam int AMPCFG_B_AUX_A_BIT = 1;
	localparam int AMPCFG_B_AUX_B_BIT = 2;
	localparam int AMPCFG_B_STALL_BIT = 6;
	localparam int AMPCFG_B_SINGLE_BIT = 7;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [7:0] AMPCFG_RST_CFG_A = 8'h00;
	localparam logic [7:0] AMPCFG_RST_CFG_B = 8'h00;
	localparam logic [7:0] AMPCFG_RST_SCRATCH = 8'h00;
	localparam logic [7:0] AMPCFG_RST_POWER = 8'h39;
	localparam logic [7:0] AMPCFG_RST_CM_TRIM = 8'h00;
	localparam logic [7:0] AMPCFG_RST_OUT_TRIM = 8'hA0;
	localparam logic [1:0] AMPCFG_RST_CONV_START = 2'h0;
	localparam logic [7:0] AMPCFG_RST_CONV_DONE = 8'h01;
	localparam logic [7:0] AMPCFG_RST_CONV_RESULT = 8'hBD;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		AMPCFG_ST_IDLE,
		AMPCFG_ST_INSTR,
		AMPCFG_ST_DATA,
		AMPCFG_ST_IGNORE
	} ampcfg_state_t;

	typedef struct packed {
		logic [7:0] power_down;
		logic [7:0] cm_trim;
		logic [7:0] out_trim;
		logic [1:0] conv_start;
	} ampcfg_ctrl_t;

	typedef struct packed {
		logic one_transfer_per_command;
		logic select_hold_pause;
		logic output_pin_enable;
		logic stream_address_ascend;
		logic bit_order_select;
	} ampcfg_iface_t;

endpackage

// ---- design/ampcfg_regs.sv ----
// Amplifier configuration register bank behind a 3/4-wire serial port
`timescale 1ns/1ps
`default_nettype none
module ampcfg_regs import ampcfg_pkg::*; #(
	parameter logic [7:0] CATEGORY_ID = 8'hA5, // Arbitrary value
	parameter logic [7:0] VARIANT_LO = 8'h12, // Arbitrary value
	parameter logic [7:0] VARIANT_HI = 8'h34, // Arbitrary value
	parameter logic [7:0] REVISION_ID = 8'h5A // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Serial port pins
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sdio_i,
	output logic spi_sdio_o,
	output logic spi_sdio_oe_o,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	// Converter status from the analog side
	input wire logic conv_done_i,
	input wire logic [7:0] conv_result_i,
	// Controls to the amplifier
	output ampcfg_ctrl_t amp_ctrl_o,
	output ampcfg_iface_t iface_o,
	output logic soft_reset_o,
	output logic aux_reset_a_o,
	output logic aux_reset_b_o
);

	// ****************************************
	// Pin synchronisers and edges
	// ****************************************
	// Pins are sampled, so the serial clock must stay below a quarter of clk_i
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic sclk_d_r;
	wire sclk_s = sync2_r[0];
	wire cs_n_s = sync2_r[1];
	wire sdi_s = sync2_r[2];
	wire sclk_rise = sclk_s && !sclk_d_r && !cs_n_s;
	wire sclk_fall = !sclk_s && sclk_d_r && !cs_n_s;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_r <= 3'h3;
			sync2_r <= 3'h3;
			sclk_d_r <= 1'b1;
		end else begin
			sync1_r <= {spi_sdio_i, spi_cs_n_i, spi_sclk_i};
			sync2_r <= sync1_r;
			sclk_d_r <= sclk_s;
		end
	end

	// ****************************************
	// Register storage
	// ****************************************
	logic [3:1] cfg_a_r;
	logic [1:0] cfg_b_r;
	logic [7:0] scratch_r;
	ampcfg_ctrl_t ctrl_r;
	logic [7:0] conv_done_r;
	logic [7:0] conv_result_r;
	logic soft_rst_r;
	logic aux_a_r;
	logic aux_b_r;

	// ****************************************
	// Frame sequencing
	// ****************************************
	ampcfg_state_t state_r;
	logic [3:0] cnt_r;
	logic done_r;
	logic rd_r;
	logic [14:0] addr_r;
	logic [15:0] word_w;
	logic sdo_bit_r;
	logic sdio_oe_r;
	logic sdo_oe_r;

	wire lsb_first = cfg_a_r[AMPCFG_A_ORDER_BIT];
	wire ascend = cfg_a_r[AMPCFG_A_ASCEND_BIT];
	wire pin_en = cfg_a_r[AMPCFG_A_PIN_BIT];
	wire single = cfg_b_r[1];
	wire in_frame = (state_r == AMPCFG_ST_INSTR) || (state_r == AMPCFG_ST_DATA);
	wire [3:0] last_bit = (state_r == AMPCFG_ST_INSTR) ? AMPCFG_INSTR_LAST : AMPCFG_DATA_LAST;
	wire byte_end = done_r && (state_r == AMPCFG_ST_DATA);
	wire wr_en = byte_end && !rd_r;
	// LSB-first bytes fill the top half of the shared shifter
	wire [7:0] wr_data = lsb_first ? word_w[15:8] : word_w[7:0];

	ampcfg_shifter #(
		.WIDTH(AMPCFG_INSTR_BITS)
	) u_shifter (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clr_i(done_r || cs_n_s),
		.shift_i(sclk_rise && in_frame),
		.lsb_first_i(lsb_first),
		.bit_i(sdi_s),
		.word_o(word_w)
	);

	function automatic logic hit(input logic [14:0] a, input logic [14:0] ofs);
		hit = (a == ofs);
	endfunction

	// ****************************************
	// Read decode
	// ****************************************
	wire [7:0] cfg_a_view = {1'b0, cfg_a_r[1], cfg_a_r[2], cfg_a_r[3], cfg_a_r[3:1], 1'b0};
	wire [7:0] cfg_b_rd = {cfg_b_r, 6'h00};
	wire [7:0] rd_byte =
		hit(addr_r, AMPCFG_OFS_CFG_A) ? cfg_a_view :
		hit(addr_r, AMPCFG_OFS_CFG_B) ? cfg_b_rd :
		hit(addr_r, AMPCFG_OFS_CATEGORY) ? CATEGORY_ID :
		hit(addr_r, AMPCFG_OFS_VARIANT_LO) ? VARIANT_LO :
		hit(addr_r, AMPCFG_OFS_VARIANT_HI) ? VARIANT_HI :
		hit(addr_r, AMPCFG_OFS_REVISION) ? REVISION_ID :
		hit(addr_r, AMPCFG_OFS_SCRATCH) ? scratch_r :
		hit(addr_r, AMPCFG_OFS_POWER) ? ctrl_r.power_down :
		hit(addr_r, AMPCFG_OFS_CM_TRIM) ? ctrl_r.cm_trim :
		hit(addr_r, AMPCFG_OFS_OUT_TRIM) ? ctrl_r.out_trim :
		hit(addr_r, AMPCFG_OFS_CONV_START) ? {6'h00, ctrl_r.conv_start} :
		hit(addr_r, AMPCFG_OFS_CONV_DONE) ? conv_done_r :
		hit(addr_r, AMPCFG_OFS_CONV_RESULT) ? conv_result_r : 8'h00;
	wire tx_bit = lsb_first ? rd_byte[cnt_r[2:0]] : rd_byte[3'h7 - cnt_r[2:0]];
	wire [14:0] addr_step = ascend ? 15'(addr_r + 15'h0001) : 15'(addr_r - 15'h0001);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || cs_n_s) begin
			state_r <= AMPCFG_ST_IDLE;
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= sclk_rise && in_frame && (cnt_r == last_bit);
			if (sclk_rise && in_frame) begin
				cnt_r <= (cnt_r == last_bit) ? 4'h0 : 4'(cnt_r + 4'h1);
			end
			case (state_r)
				AMPCFG_ST_IDLE: state_r <= AMPCFG_ST_INSTR;
				AMPCFG_ST_INSTR: state_r <= done_r ? AMPCFG_ST_DATA : AMPCFG_ST_INSTR;
				AMPCFG_ST_DATA: state_r <= (byte_end && single) ? AMPCFG_ST_IGNORE : AMPCFG_ST_DATA;
				AMPCFG_ST_IGNORE: state_r <= AMPCFG_ST_IGNORE;
				default: state_r <= AMPCFG_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_r <= 1'b0;
			addr_r <= '0;
		end else if (done_r && state_r == AMPCFG_ST_INSTR) begin
			rd_r <= word_w[15];
			addr_r <= word_w[14:0];
		end else if (byte_end && !single) begin
			addr_r <= addr_step;
		end
	end

	// ****************************************
	// Readback drive
	// ****************************************
	// Three-wire turns the shared data pin around; four-wire keeps it input only
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || cs_n_s) begin
			sdo_bit_r <= 1'b0;
			sdio_oe_r <= 1'b0;
			sdo_oe_r <= 1'b0;
		end else begin
			if (sclk_fall && state_r == AMPCFG_ST_DATA && rd_r) begin
				sdo_bit_r <= tx_bit;
			end
			sdio_oe_r <= rd_r && state_r == AMPCFG_ST_DATA && !pin_en;
			sdo_oe_r <= rd_r && state_r == AMPCFG_ST_DATA && pin_en;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	// Soft reset lands one cycle after the write, restoring every writable register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || soft_rst_r) begin
			cfg_a_r <= AMPCFG_RST_CFG_A[3:1];
			cfg_b_r <= AMPCFG_RST_CFG_B[7:6];
			scratch_r <= AMPCFG_RST_SCRATCH;
			ctrl_r <= '{AMPCFG_RST_POWER, AMPCFG_RST_CM_TRIM, AMPCFG_RST_OUT_TRIM, AMPCFG_RST_CONV_START};
		end else if (wr_en) begin
			if (hit(addr_r, AMPCFG_OFS_CFG_A)) cfg_a_r <= wr_data[3:1];
			if (hit(addr_r, AMPCFG_OFS_CFG_B)) cfg_b_r <= wr_data[7:6];
			if (hit(addr_r, AMPCFG_OFS_SCRATCH)) scratch_r <= wr_data;
			if (hit(addr_r, AMPCFG_OFS_POWER)) ctrl_r.power_down <= wr_data;
			if (hit(addr_r, AMPCFG_OFS_CM_TRIM)) ctrl_r.cm_trim <= wr_data;
			if (hit(addr_r, AMPCFG_OFS_OUT_TRIM)) ctrl_r.out_trim <= wr_data;
			if (hit(addr_r, AMPCFG_OFS_CONV_START)) ctrl_r.conv_start <= wr_data[1:0];
		end
	end

	// Reset and pulse bits are never stored, so they always read back zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			soft_rst_r <= 1'b0;
			aux_a_r <= 1'b0;
			aux_b_r <= 1'b0;
			conv_done_r <= AMPCFG_RST_CONV_DONE;
			conv_result_r <= AMPCFG_RST_CONV_RESULT;
		end else begin
			soft_rst_r <= wr_en && hit(addr_r, AMPCFG_OFS_CFG_A) && wr_data[AMPCFG_A_RESET_BIT];
			aux_a_r <= wr_en && hit(addr_r, AMPCFG_OFS_CFG_B) && wr_data[AMPCFG_B_AUX_A_BIT];
			aux_b_r <= wr_en && hit(addr_r, AMPCFG_OFS_CFG_B) && wr_data[AMPCFG_B_AUX_B_BIT];
			conv_done_r <= {7'h00, conv_done_i};
			conv_result_r <= conv_result_i;
		end
	end

	assign spi_sdio_o = sdo_bit_r;
	assign spi_sdio_oe_o = sdio_oe_r;
	assign spi_sdo_o = sdo_bit_r;
	assign spi_sdo_oe_o = sdo_oe_r;
	assign amp_ctrl_o = ctrl_r;
	assign iface_o = {cfg_b_r, cfg_a_r[3], cfg_a_r[2], cfg_a_r[1]};
	assign soft_reset_o = soft_rst_r;
	assign aux_reset_a_o = aux_a_r;
	assign aux_reset_b_o = aux_b_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_cfg_a_reset_write;
		wr_en && hit(addr_r, AMPCFG_OFS_CFG_A) && wr_data[0];
	endsequence
	sequence s_cfg_b_aux_write;
		wr_en && hit(addr_r, AMPCFG_OFS_CFG_B) && wr_data[1];
	endsequence

	chk_soft_reset_clears: assert property (s_cfg_a_reset_write |=> soft_reset_o ##1 (cfg_a_view == 8'h00 && !soft_reset_o && ctrl_r.out_trim == 8'hA0))
		else $error("soft reset did not restore and self-clear");
	chk_mirror_bits: assert property (cfg_a_view[7:4] == {cfg_a_view[0], cfg_a_view[1], cfg_a_view[2], cfg_a_view[3]})
		else $error("config A mirror bits wrong");
	chk_four_wire_pin: assert property ((spi_sdo_oe_o |-> $past(pin_en)) and (spi_sdio_oe_o |-> !$past(pin_en)))
		else $error("readback pin does not follow output pin enable");
	chk_stream_addr_step: assert property (byte_end && !single |=> addr_r == ($past(ascend) ? 15'($past(addr_r) + 15'h0001) : 15'($past(addr_r) - 15'h0001)))
		else $error("streaming address step wrong");
	chk_bit_order_tx: assert property (sclk_fall && state_r == AMPCFG_ST_DATA && rd_r |=> sdo_bit_r == ($past(lsb_first) ? $past(rd_byte[cnt_r[2:0]]) : $past(rd_byte[3'h7 - cnt_r[2:0]])))
		else $error("readback bit order wrong");
	chk_single_transfer: assert property (byte_end && single && !cs_n_s |=> state_r == AMPCFG_ST_IGNORE ##1 !wr_en)
		else $error("single instruction did not end transfer");
	chk_aux_pulse_once: assert property (s_cfg_b_aux_write |=> aux_reset_a_o ##1 !aux_reset_a_o && cfg_b_rd[1] == 1'b0)
		else $error("aux reset A did not pulse once");
	chk_scratch_hold: assert property (scratch_r != $past(scratch_r) |-> $past(wr_en && hit(addr_r, AMPCFG_OFS_SCRATCH)) || $past(soft_rst_r))
		else $error("scratch byte changed without a write");

endmodule
`default_nettype wire

// ---- design/ampcfg_shifter.sv ----
// Serial input shift register with selectable bit order
`timescale 1ns/1ps
`default_nettype none
module ampcfg_shifter #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic clr_i,
	input wire logic shift_i,
	input wire logic lsb_first_i,
	input wire logic bit_i,
	// Assembled word
	output logic [WIDTH-1:0] word_o
);

	logic [WIDTH-1:0] word_r;
	logic [WIDTH-1:0] word_nxt;

	// LSB-first fills from the top so the last bit lands at the top, first bit in bit 0
	assign word_nxt = lsb_first_i ? {bit_i, word_r[WIDTH-1:1]} : {word_r[WIDTH-2:0], bit_i};
	assign word_o = word_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clr_i) begin
			word_r <= '0;
		end else if (shift_i) begin
			word_r <= word_nxt;
		end
	end

endmodule
`default_nettype wire
